// >>> src/csk_map.vh
// constants for the compare-and-skip decode and execute block
// assumes a 16-bit program word and an 8-bit data path
`ifndef CSK_MAP_VH
`define CSK_MAP_VH
`define CSK_OP_FAMILY     4'h6
`define CSK_OP_HI         15
`define CSK_OP_LO         12
`define CSK_SUB_HI        11
`define CSK_SUB_LO        9
`define CSK_BANK_BIT      8
`define CSK_FADDR_HI      7
`define CSK_FADDR_LO      0
`define CSK_SUB_LESS      3'h0
`define CSK_SUB_EQUAL     3'h1
`define CSK_SUB_GREATER   3'h2
`define CSK_IDX_MAX       8'h5F
`define CSK_ACC_SPLIT     8'h60
`define CSK_ACC_HI_BANK   4'hF
`define CSK_QPH_RST       4'h1
`endif

// >>> src/csk_compare_skip.v
// compare-and-skip decode and execute logic for an 8-bit core
// assumes a fetch stage giving each word at q1 with a two-word flag,
// and a data memory that returns the addressed byte by q3
`timescale 1ns/1ps
`include "csk_map.vh"

// Summary of operation
// - decode top nibble 0110, sub-opcode 000 less, 001 equal, 010 greater.
// - less-than carries bank bit at bit 8, file address in low byte.
// - file address spans 0 to 255; bank bit is zero or one.
// - greater skips only when byte strictly exceeds accumulator, unsigned.
// - less skips only when byte strictly below accumulator, unsigned.
// - equal skips when byte equals accumulator, else continues normally.
// - on skip, discard fetched word and run a no-operation cycle.
// - one word, one cycle; skipping a two-word instruction costs two no-op cycles.
// - q1 decode, q2 read file, q3 process, q4 no write-back.
// - bank bit zero uses access bank; one uses bank select register.
// - bank bit zero, extended set on, address up to 95: indexed offset.
// - no flags changed, no result written to accumulator or file.
// - all three compares share the same timing and quarter-phase pattern.
module csk_compare_skip (
  input  wire        ref_clk,
  input  wire        rst_b,
  input  wire [15:0] instr_word,
  input  wire        instr_valid,
  input  wire        next_is_two_word,
  input  wire [7:0]  working_accumulator_reg,
  input  wire [3:0]  bank_select_register,
  input  wire        ext_set_enable,
  input  wire [7:0]  index_base,
  input  wire [7:0]  file_rd_data,
  output reg  [3:0]  qphase,
  output reg         file_rd_en,
  output reg  [11:0] file_rd_addr,
  output reg         cmp_active,
  output reg         skip_taken,
  output reg         squash_fetch,
  output reg         nop_cycle,
  output reg         flags_write_en,
  output reg         result_write_en
);

  // quarter phases, one-hot
  localparam [3:0] Q1 = 4'h1;
  localparam [3:0] Q2 = 4'h2;
  localparam [3:0] Q3 = 4'h4;
  localparam [3:0] Q4 = 4'h8;

  // cycle states, one-hot
  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_NOP1 = 3'h2;
  localparam [2:0] ST_NOP2 = 3'h4;

  reg        rst_meta_r;
  reg        rst_sync_r;
  wire       rst_n;

  reg [3:0]  qphase_nxt;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [2:0]  sub_r;
  reg        bank_r;
  reg [7:0]  faddr_r;
  reg        two_word_r;
  reg        is_cmp_r;
  reg        cond;
  reg [11:0] addr_nxt;
  wire       is_cmp;
  wire [2:0] sub_op;
  wire [8:0] diff;
  wire [8:0] borrow;
  wire       fam_hit;
  reg        sub_known;
  reg        is_cmp_nxt;
  reg [2:0]  sub_nxt;
  reg        bank_nxt;
  reg [7:0]  faddr_nxt;
  reg        two_word_nxt;
  reg        cmp_active_nxt;
  reg        rd_en_nxt;
  reg [11:0] rd_addr_nxt;
  reg        skip_nxt;
  reg        nop_nxt;
  genvar     gi;

  // reset released through two stages
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  assign sub_op = instr_word[`CSK_SUB_HI:`CSK_SUB_LO];
  assign fam_hit = instr_valid &&
                   (instr_word[`CSK_OP_HI:`CSK_OP_LO] == `CSK_OP_FAMILY);

  // sub-opcodes 3 to 7 belong to other instructions and are left alone
  always @* begin
    case (sub_op)
      `CSK_SUB_LESS:    sub_known = 1'b1;
      `CSK_SUB_EQUAL:   sub_known = 1'b1;
      `CSK_SUB_GREATER: sub_known = 1'b1;
      default:          sub_known = 1'b0;
    endcase
  end
  assign is_cmp = fam_hit && sub_known;

  // ripple borrow chain, file minus accumulator; a compare has a whole
  // phase to settle, so look-ahead would buy nothing here
  assign borrow[0] = 1'b0;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sub
      wire fbit;
      wire abit;
      assign fbit           = file_rd_data[gi];
      assign abit           = working_accumulator_reg[gi];
      assign diff[gi]       = fbit ^ abit ^ borrow[gi];
      assign borrow[gi + 1] = (~fbit & abit) | (~(fbit ^ abit) & borrow[gi]);
    end
  endgenerate
  // final borrow set means file byte below accumulator
  assign diff[8] = borrow[8];

  always @* begin
    case (sub_r)
      `CSK_SUB_LESS:    cond = diff[8];
      `CSK_SUB_EQUAL:   cond = (diff[7:0] == 8'h00);
      `CSK_SUB_GREATER: cond = !diff[8] && (diff[7:0] != 8'h00);
      default:          cond = 1'b0;
    endcase
  end

  // data address: access bank, banked, or indexed offset
  always @* begin
    if (bank_r) begin
      addr_nxt = {bank_select_register, faddr_r};
    end else if (ext_set_enable && (faddr_r <= `CSK_IDX_MAX)) begin
      // wraps within the low byte; a wider index is outside this block
      addr_nxt = {4'h0, index_base + faddr_r};
    end else if (faddr_r < `CSK_ACC_SPLIT) begin
      addr_nxt = {4'h0, faddr_r};
    end else begin
      addr_nxt = {`CSK_ACC_HI_BANK, faddr_r};
    end
  end

  always @* begin
    case (qphase)
      Q1:      qphase_nxt = Q2;
      Q2:      qphase_nxt = Q3;
      Q3:      qphase_nxt = Q4;
      Q4:      qphase_nxt = Q1;
      default: qphase_nxt = Q1;
    endcase
  end

  // skip choice made at q4 so the squash and the move into the no-op state take the same edge
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (qphase == Q4 && is_cmp_r && cond) begin
          state_nxt = ST_NOP1;
        end
      end
      ST_NOP1: begin
        if (qphase == Q4) begin
          state_nxt = two_word_r ? ST_NOP2 : ST_RUN;
        end
      end
      ST_NOP2: begin
        if (qphase == Q4) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  // q1 capture; words offered during an inserted no-op are ignored
  always @* begin
    is_cmp_nxt     = is_cmp_r;
    sub_nxt        = sub_r;
    bank_nxt       = bank_r;
    faddr_nxt      = faddr_r;
    two_word_nxt   = two_word_r;
    cmp_active_nxt = cmp_active;
    if (qphase == Q1) begin
      if (state_r == ST_RUN) begin
        is_cmp_nxt     = is_cmp;
        sub_nxt        = sub_op;
        bank_nxt       = instr_word[`CSK_BANK_BIT];
        faddr_nxt      = instr_word[`CSK_FADDR_HI:`CSK_FADDR_LO];
        two_word_nxt   = next_is_two_word;
        cmp_active_nxt = is_cmp;
      end else begin
        is_cmp_nxt     = 1'b0;
        cmp_active_nxt = 1'b0;
      end
    end
  end

  // q2 read; the address holds until the next compare reads
  always @* begin
    rd_en_nxt   = 1'b0;
    rd_addr_nxt = file_rd_addr;
    if (qphase == Q2 && is_cmp_r && state_r == ST_RUN) begin
      rd_en_nxt   = 1'b1;
      rd_addr_nxt = addr_nxt;
    end
  end

  // q4 decision, a one-phase pulse seen during the next q1
  always @* begin
    skip_nxt = 1'b0;
    if (qphase == Q4 && is_cmp_r && state_r == ST_RUN) begin
      skip_nxt = cond;
    end
  end

  // no-op flag follows the next state so it rises with the squash
  always @* begin
    nop_nxt = (state_nxt != ST_RUN);
  end

  // quarter-phase ring
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qphase <= `CSK_QPH_RST;
    end else begin
      qphase <= qphase_nxt;
    end
  end

  // live or inserted no-op cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_RUN;
      nop_cycle <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      nop_cycle <= nop_nxt;
    end
  end

  // decoded fields of the word in flight
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_cmp_r   <= 1'b0;
      sub_r      <= 3'h0;
      bank_r     <= 1'b0;
      faddr_r    <= 8'h00;
      two_word_r <= 1'b0;
      cmp_active <= 1'b0;
    end else begin
      is_cmp_r   <= is_cmp_nxt;
      sub_r      <= sub_nxt;
      bank_r     <= bank_nxt;
      faddr_r    <= faddr_nxt;
      two_word_r <= two_word_nxt;
      cmp_active <= cmp_active_nxt;
    end
  end

  // data memory request
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_rd_en   <= 1'b0;
      file_rd_addr <= 12'h000;
    end else begin
      file_rd_en   <= rd_en_nxt;
      file_rd_addr <= rd_addr_nxt;
    end
  end

  // skip outputs; both come from one decision so they never disagree
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      skip_taken   <= 1'b0;
      squash_fetch <= 1'b0;
    end else begin
      skip_taken   <= skip_nxt;
      squash_fetch <= skip_nxt;
    end
  end

  // compares never touch status or destination
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_write_en  <= 1'b0;
      result_write_en <= 1'b0;
    end else begin
      flags_write_en  <= 1'b0;
      result_write_en <= 1'b0;
    end
  end

endmodule // csk_compare_skip

// >>> sim/csk_chk.sv
// port checker for the compare-and-skip block
// assumes a bind from the bench top
`timescale 1ns/1ps
module csk_chk (
  input logic        ref_clk,
  input logic        rst_b,
  input logic [15:0] instr_word,
  input logic        instr_valid,
  input logic [3:0]  qphase,
  input logic        file_rd_en,
  input logic        cmp_active,
  input logic        skip_taken,
  input logic        squash_fetch,
  input logic        nop_cycle,
  input logic        flags_write_en,
  input logic        result_write_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire take_w = qphase == 4'h1 && !nop_cycle && instr_valid && instr_word[15:12] == 4'h6;
  AST_NO_STORE: assert property (!flags_write_en && !result_write_en) else $error("store");
  AST_ONEHOT: assert property ($onehot(qphase)) else $error("phase");
  AST_ROTATE: assert property (qphase == 4'h2 |=> qphase == 4'h4) else $error("order");
  AST_SQUASH: assert property (squash_fetch == skip_taken) else $error("squash");
  AST_SKIP_Q1: assert property (skip_taken |-> qphase == 4'h1 && nop_cycle) else $error("skip");
  AST_NOP_LEN: assert property ($rose(nop_cycle) |-> nop_cycle[*4]) else $error("nop");
  AST_NOP_QUIET: assert property (nop_cycle |-> !file_rd_en) else $error("nop read");
  AST_RD_ACT: assert property (file_rd_en |-> cmp_active) else $error("read");
  AST_DECODE: assert property (take_w && instr_word[11:9] < 3'h3 |-> ##[1:3] file_rd_en)
    else $error("decode");
  AST_REFUSE: assert property (take_w && instr_word[11:9] > 3'h2 |=> !file_rd_en[*4])
    else $error("refuse");
endmodule // csk_chk

// >>> sim/csk_file_mem.sv
// banked data memory answering file reads
// assumes the bench preloads mem
`timescale 1ns/1ps
module csk_file_mem (
  input  logic        cmp_active,
  input  logic [11:0] file_rd_addr,
  output logic [7:0]  file_rd_data
);
  logic [7:0] mem [0:4095];
  // inverse outside a compare so a stray sample never matches
  assign file_rd_data = cmp_active ? mem[file_rd_addr] : ~mem[file_rd_addr];
endmodule // csk_file_mem

// >>> sim/compare_skip_instructions_test.sv
// bench for the compare-and-skip block
// assumes inputs move on the falling edge
`timescale 1ns/1ps
module compare_skip_instructions_test;
  logic ref_clk = 0, rst_b = 0, instr_valid = 0, next_is_two_word = 0, ext_set_enable = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [7:0]  working_accumulator_reg = 8'h00, index_base = 8'h10, file_rd_data;
  logic [3:0]  bank_select_register = 4'h3, qphase;
  logic [11:0] file_rd_addr;
  logic        file_rd_en, cmp_active, skip_taken, squash_fetch, nop_cycle;
  logic        flags_write_en, result_write_en;
  int          errors = 0, tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  csk_compare_skip dut (.ref_clk, .rst_b, .instr_word, .instr_valid, .next_is_two_word,
    .working_accumulator_reg, .bank_select_register, .ext_set_enable, .index_base,
    .file_rd_data, .qphase, .file_rd_en, .file_rd_addr, .cmp_active, .skip_taken,
    .squash_fetch, .nop_cycle, .flags_write_en, .result_write_en);
  csk_file_mem mem_u (.cmp_active, .file_rd_addr, .file_rd_data);
  task chk(input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task run(input [2:0] sub, input a, input [7:0] f, v, w, input tw);
    logic [11:0] ad;
    logic sk;
    int n;
    ad = a ? {bank_select_register, f} :
         (ext_set_enable && f <= 8'h5F) ? {4'h0, index_base + f} :
         {(f < 8'h60) ? 4'h0 : 4'hF, f};
    sk = sub == 0 ? v < w : sub == 1 ? v == w : sub == 2 ? v > w : 1'b0;
    mem_u.mem[ad] = v;
    n = 0;
    while ((qphase !== 4'h1 || nop_cycle !== 1'b0) && n < 20) begin
      n++;
      @(negedge ref_clk);
    end
    instr_word = {4'h6, sub, a, f};
    instr_valid = 1;
    working_accumulator_reg = w;
    next_is_two_word = tw;
    @(negedge ref_clk);
    instr_valid = 0;
    // skip pulse stands only during the following q1
    repeat (3) @(negedge ref_clk);
    chk(skip_taken, sk);
    chk(squash_fetch, sk);
    chk(cmp_active, sub < 3);
    if (sub < 3) chk(file_rd_addr, ad);
    n = 0;
    repeat (10) begin
      n += nop_cycle;
      @(negedge ref_clk);
    end
    chk(12'(n), sk ? (tw ? 12'h008 : 12'h004) : 12'h000);
  endtask
  initial begin
    for (int i = 0; i < 4096; i++) mem_u.mem[i] = 8'h00;
    repeat (12) @(negedge ref_clk);
    rst_b = 1;
    // block releases its own reset two edges later
    repeat (2) @(negedge ref_clk);
    run(3'h0, 1'b0, 8'h20, 8'h10, 8'h11, 1'b0);
    run(3'h0, 1'b0, 8'h20, 8'h11, 8'h11, 1'b0);
    run(3'h1, 1'b1, 8'hFF, 8'h7F, 8'h7F, 1'b1);
    run(3'h1, 1'b0, 8'h60, 8'h00, 8'hFF, 1'b0);
    run(3'h2, 1'b0, 8'h5F, 8'hFF, 8'h00, 1'b0);
    run(3'h2, 1'b1, 8'h00, 8'h80, 8'h80, 1'b0);
    ext_set_enable = 1;
    run(3'h0, 1'b0, 8'h05, 8'h30, 8'h20, 1'b0);
    run(3'h2, 1'b1, 8'h10, 8'h01, 8'h02, 1'b1);
    run(3'h0, 1'b0, 8'hA0, 8'h00, 8'h01, 1'b1);
    run(3'h3, 1'b0, 8'h20, 8'h00, 8'h01, 1'b0);
    print_verdict;
  end
  initial begin
    #100000;
    errors++;
    print_verdict;
  end
endmodule // compare_skip_instructions_test
bind csk_compare_skip csk_chk chk_u (.ref_clk, .rst_b, .instr_word, .instr_valid, .qphase,
  .file_rd_en, .cmp_active, .skip_taken, .squash_fetch, .nop_cycle, .flags_write_en,
  .result_write_en);
